// >>> dv/irsc_props.sv
// Link checker for the resizer channel and its controller
`timescale 1ns/1ps
module irsc_props (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic reg_wr,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic vsync_event,
  input wire logic px_is_422,
  input wire logic px_ready,
  input wire logic out_valid,
  input wire logic out_y_en,
  input wire logic out_c_en,
  input wire logic out_line_end,
  input wire logic out_frame_end
);
  import irsc_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of the settings seen on the link
  // ----------------------------------------------------------------
  logic [12:0] wid_q, lines_q, px_q, ln_q;
  logic [1:0] sub_q;
  logic done_q;
  // No clamp modelled: the bench keeps the width inside the limit
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wid_q <= '0;
      lines_q <= '0;
      sub_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        IDX_O_WIDTH: wid_q <= {reg_wdata[12:1], 1'b0};
        IDX_O_LINES: lines_q <= reg_wdata[12:0];
        IDX_SUBSMP: sub_q <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET || vsync_event || (out_valid && out_line_end)) px_q <= '0;
    else if (out_valid) px_q <= px_q + 13'h1;
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET || vsync_event) ln_q <= '0;
    else if (out_line_end) ln_q <= ln_q + 13'h1;
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET || vsync_event) done_q <= 1'b0;
    else if (out_frame_end) done_q <= 1'b1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence tail_s;
    out_line_end ##1 !out_valid;
  endsequence
  emit_after_stall_a: assert property (out_valid |-> $past(px_ready) == 1'b0)
    else $error("output pixel without a stall cycle");
  line_width_a: assert property (out_valid && out_line_end |-> px_q == wid_q)
    else $error("wrong pixel count in line");
  line_count_a: assert property (out_frame_end |-> ln_q == lines_q)
    else $error("wrong line count in frame");
  frame_tail_a: assert property (out_frame_end |-> tail_s)
    else $error("frame end not closing a line");
  frame_quiet_a: assert property (done_q |-> !out_valid)
    else $error("pixel after frame end");
  end_valid_a: assert property (out_line_end |-> out_valid)
    else $error("line end without pixel");
  fmt_422_a: assert property (out_valid && (!px_is_422 || sub_q == 2'b00)
    |-> out_y_en && out_c_en)
    else $error("full format lost a component");
  luma_only_a: assert property (out_valid && px_is_422 && sub_q == 2'b01
    |-> out_y_en && !out_c_en)
    else $error("luma only mode wrong");
  chroma_only_a: assert property (out_valid && px_is_422 && sub_q == 2'b10
    |-> !out_y_en)
    else $error("chroma only mode gave luma");
endmodule : irsc_props

// >>> dv/tb.sv
// Testbench: APB programming, pixel frames, sink counts
`timescale 1ns/1ps
module tb;
  import irsc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, lerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic vs, i422, sv, sle, sr, ov, oye, oce, ole, ofe, dwn, fa;
  logic [15:0] sd;
  logic [7:0] oy, oc, fy, fc;
  logic [1:0] vm;
  logic [11:0] vsm;
  logic [13:0] vpy, vpc;
  int num_errors = 0, samples_checked = 0, n_px, n_y, n_c, n_ln, n_fr;
  logic [4:0] ti [4] = '{IDX_IN_HST, IDX_O_WIDTH, IDX_H_PH, IDX_H_PH_ADJ};
  logic [31:0] tv [4] = '{32'h1fff, 32'h3, 32'h2200, 32'h1ff};
  logic [31:0] te [4] = '{32'h1ffe, 32'h2, 32'h2200, 32'h1ff};
  logic [1:0] msub [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic mis [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  int mey [4] = '{6, 0, 6, 6};
  int mec [4] = '{0, 3, 3, 6};
  irsc_link_if link();
  irsc_dev irsc_dev_i (.REF_CLK(clk), .RESET(rst), .LINK(link), .V_METHOD(vm),
    .V_SMOOTH(vsm), .V_PHASE_Y(vpy), .V_PHASE_C(vpc), .DOWNSCALE(dwn), .FRAME_ACTIVE(fa));
  irsc_host irsc_host_i (.REF_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SRC_VSYNC(vs), .SRC_IS_422(i422), .SRC_VALID(sv), .SRC_DATA(sd),
    .SRC_LINE_END(sle), .SRC_READY(sr), .SNK_VALID(ov), .SNK_Y(oy), .SNK_C(oc),
    .SNK_Y_EN(oye), .SNK_C_EN(oce), .SNK_LINE_END(ole), .SNK_FRAME_END(ofe), .LINK(link));
  irsc_props irsc_props_i (.REF_CLK(clk), .RESET(rst), .reg_wr(link.reg_wr),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .vsync_event(link.vsync_event),
    .px_is_422(link.px_is_422), .px_ready(link.px_ready), .out_valid(link.out_valid),
    .out_y_en(link.out_y_en), .out_c_en(link.out_c_en), .out_line_end(link.out_line_end),
    .out_frame_end(link.out_frame_end));
  // ----------------------------------------------------------------
  // Clock, sink monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ov === 1'b1) begin
      if (n_px == 0) begin
        fy = oy;
        fc = oc;
      end
      n_px++;
      if (oye === 1'b1) n_y++;
      if (oce === 1'b1) n_c++;
    end
    if (ole === 1'b1) n_ln++;
    if (ofe === 1'b1) n_fr++;
  end
  initial begin
    #3000000;
    num_errors++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Request held until pready seen high; data and error taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic dcmd(input logic [4:0] idx, input logic [31:0] d, input logic [1:0] op);
    int k;
    apb(1'b1, APB_CMD_ADDR, {27'h0, idx});
    apb(1'b1, APB_CMD_DATA, d);
    apb(1'b1, APB_CMD_CTRL, {30'h0, op});
    k = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 20);
    if (k >= 20) chk("busy", 32'h0, 32'h1);
    apb(1'b0, APB_CMD_RDATA, 32'h0);
  endtask : dcmd
  task automatic dw(input logic [4:0] idx, input logic [31:0] d);
    dcmd(idx, d, 2'b01);
  endtask : dw
  task automatic dr(input logic [4:0] idx);
    dcmd(idx, 32'h0, 2'b10);
  endtask : dr
  // Four source lines of ten pixels; Y carries the line, C the pixel index
  task automatic frame(input logic is422);
    n_px = 0;
    n_y = 0;
    n_c = 0;
    n_ln = 0;
    n_fr = 0;
    @(posedge clk);
    i422 <= is422;
    vs <= 1'b1;
    @(posedge clk);
    vs <= 1'b0;
    for (int l = 0; l < 4; l++) begin
      for (int p = 0; p < 10; p++) begin
        sv <= 1'b1;
        sd <= {8'(l), 8'(p)};
        sle <= (p == 9);
        do @(posedge clk); while (sr !== 1'b1);
      end
    end
    sv <= 1'b0;
    sle <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : frame
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {vs, i422, sv, sle, sd} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i <= 16; i++) begin
      dr(5'(i));
      chk("reset", (5'(i) == IDX_V_RATIO || 5'(i) == IDX_H_RATIO) ? 32'h100 : 32'h0, rd);
    end
    dr(5'h1f);
    chk("unmapped index", 32'h0, rd);
    apb(1'b1, 8'h20, 32'h1);
    chk("unmapped apb", 32'h1, {31'h0, lerr});
    chk("pready", 32'h1, {31'h0, pready});
    for (int i = 0; i < 4; i++) begin
      dw(ti[i], tv[i]);
      dr(ti[i]);
      chk("readback", te[i], rd);
    end
    dw(IDX_V_PH_Y, 32'h2710);
    dw(IDX_V_PH_C, 32'h1234);
    dw(IDX_V_METH, 32'h3);
    dw(IDX_V_SMOOTH, 32'h820);
    dw(IDX_DWN, 32'h1);
    chk("v_phase_y", 32'h2710, {18'h0, vpy});
    chk("v_phase_c", 32'h1234, {18'h0, vpc});
    chk("v_method", 32'h3, {30'h0, vm});
    chk("v_smooth", 32'h820, {20'h0, vsm});
    chk("downscale", 32'h1, {31'h0, dwn});
    dw(IDX_H_PH, 32'h0);
    dw(IDX_H_PH_ADJ, 32'h0);
    dw(IDX_V_PH_Y, 32'h0);
    dw(IDX_DWN, 32'h0);
    dw(IDX_H_METH, 32'h3);
    dr(IDX_H_METH);
    chk("h_method", 32'h3, rd);
    dw(IDX_IN_VST, 32'h1);
    dw(IDX_IN_HST, 32'h2);
    dw(IDX_O_WIDTH, 32'h3);
    dw(IDX_O_LINES, 32'h1);
    dw(IDX_SINGLE, 32'h1);
    dw(IDX_SUBSMP, 32'h0);
    dw(IDX_ENABLE, 32'h1);
    frame(1'b1);
    chk("pixels", 32'd6, n_px);
    chk("lines", 32'd2, n_ln);
    chk("frame ends", 32'd1, n_fr);
    chk("first y", 32'h1, {24'h0, fy});
    chk("first c", 32'h2, {24'h0, fc});
    chk("frame active", 32'h1, {31'h0, fa});
    dr(IDX_ENABLE);
    chk("enable one-shot", 32'h0, rd);
    frame(1'b1);
    chk("disabled pixels", 32'd0, n_px);
    chk("frame idle", 32'h0, {31'h0, fa});
    dw(IDX_SINGLE, 32'h0);
    dw(IDX_ENABLE, 32'h1);
    // Continuous run: each frame must restart its counts
    for (int m = 0; m < 4; m++) begin
      dw(IDX_SUBSMP, {30'h0, msub[m]});
      frame(mis[m]);
      chk("luma count", mey[m], n_y);
      chk("chroma count", mec[m], n_c);
    end
    dr(IDX_ENABLE);
    chk("enable continuous", 32'h1, rd);
    summarize();
  end
endmodule : tb

// >>> pkg/irsc_link_if.sv
// Link between the resizer channel and the controller/pixel pipe
`timescale 1ns/1ps
interface irsc_link_if;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic vsync_event;
  logic px_is_422;
  logic px_valid;
  logic px_ready;
  logic [15:0] px_data;
  logic px_line_end;
  logic out_valid;
  logic [7:0] out_y;
  logic [7:0] out_c;
  logic out_y_en;
  logic out_c_en;
  logic out_line_end;
  logic out_frame_end;

  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata, vsync_event, px_is_422,
    input px_valid, px_data, px_line_end,
    output reg_rdata, px_ready, out_valid, out_y, out_c, out_y_en, out_c_en,
    output out_line_end, out_frame_end
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, vsync_event, px_is_422,
    output px_valid, px_data, px_line_end,
    input reg_rdata, px_ready, out_valid, out_y, out_c, out_y_en, out_c_en,
    input out_line_end, out_frame_end
  );
endinterface : irsc_link_if

// >>> pkg/irsc_pkg.sv
// Shared constants for the resizer second channel and its controller
package irsc_pkg;

  // ----------------------------------------------------------------
  // Device register indexes
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_ENABLE = 5'h00;
  localparam logic [4:0] IDX_SINGLE = 5'h01;
  localparam logic [4:0] IDX_SUBSMP = 5'h02;
  localparam logic [4:0] IDX_IN_VST = 5'h03;
  localparam logic [4:0] IDX_IN_HST = 5'h04;
  localparam logic [4:0] IDX_O_LINES = 5'h05;
  localparam logic [4:0] IDX_O_WIDTH = 5'h06;
  localparam logic [4:0] IDX_V_PH_Y = 5'h07;
  localparam logic [4:0] IDX_V_PH_C = 5'h08;
  localparam logic [4:0] IDX_V_RATIO = 5'h09;
  localparam logic [4:0] IDX_V_METH = 5'h0a;
  localparam logic [4:0] IDX_V_SMOOTH = 5'h0b;
  localparam logic [4:0] IDX_H_PH = 5'h0c;
  localparam logic [4:0] IDX_H_PH_ADJ = 5'h0d;
  localparam logic [4:0] IDX_H_RATIO = 5'h0e;
  localparam logic [4:0] IDX_H_METH = 5'h0f;
  localparam logic [4:0] IDX_DWN = 5'h10;

  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int POS_W = 13;
  localparam int PH_W = 14;
  localparam int ADJ_W = 9;
  localparam int SMOOTH_W = 6;
  localparam int ACC_W = 22;
  localparam int FRAC_W = 8;
  localparam logic [PH_W-1:0] RATIO_RESET = 14'h0100;
  localparam logic [PH_W-1:0] RATIO_MIN_NORMAL = 14'h0010;
  localparam logic [PH_W-1:0] RATIO_MIN_DOWN = 14'h0100;
  localparam logic [PH_W-1:0] RATIO_MAX = 14'h1000;
  localparam logic [POS_W-1:0] WIDTH_MAX_NORMAL = 13'h0440;
  localparam logic [POS_W-1:0] WIDTH_MAX_DOWN = 13'h0220;

  // ----------------------------------------------------------------
  // Controller APB byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] APB_CMD_ADDR = 8'h00;
  localparam logic [7:0] APB_CMD_DATA = 8'h04;
  localparam logic [7:0] APB_CMD_CTRL = 8'h08;
  localparam logic [7:0] APB_CMD_RDATA = 8'h0c;
  localparam logic [7:0] APB_STATUS = 8'h10;
  localparam int CTRL_WR_BIT = 0;
  localparam int CTRL_RD_BIT = 1;

endpackage : irsc_pkg

// >>> rtl/irsc_dev.sv
// Resizer second channel: configuration registers and streaming resizer
`timescale 1ns/1ps
module irsc_dev (
  input wire logic REF_CLK,
  input wire logic RESET,
  irsc_link_if.dev LINK,
  output logic [1:0] V_METHOD,
  output logic [11:0] V_SMOOTH,
  output logic [13:0] V_PHASE_Y,
  output logic [13:0] V_PHASE_C,
  output logic DOWNSCALE,
  output logic FRAME_ACTIVE
);
  import irsc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PH_W-1:0] eff_ratio(input logic [PH_W-1:0] v, input logic dwn);
    logic [PH_W-1:0] lo;
    lo = dwn ? RATIO_MIN_DOWN : RATIO_MIN_NORMAL;
    if (v < lo) begin
      eff_ratio = lo;
    end else if (v > RATIO_MAX) begin
      eff_ratio = RATIO_MAX;
    end else begin
      eff_ratio = v;
    end
  endfunction : eff_ratio

  // Catmull-Rom when cubic, else 2-tap between p1 and p2
  function automatic logic [7:0] interp(input logic [31:0] p, input logic [7:0] f,
                                        input logic linear);
    logic signed [21:0] t;
    logic signed [21:0] t2;
    logic signed [21:0] t3;
    logic signed [21:0] acc;
    t = {14'h0000, f};
    t2 = (t * t) >>> 8;
    t3 = (t2 * t) >>> 8;
    if (linear) begin
      acc = (22'sd256 - t) * $signed({14'h0000, p[15:8]}) + t * $signed({14'h0000, p[23:16]});
    end else begin
      acc = ((-t3 + 22'sd2 * t2 - t) >>> 1) * $signed({14'h0000, p[7:0]})
          + ((22'sd3 * t3 - 22'sd5 * t2 + 22'sd512) >>> 1) * $signed({14'h0000, p[15:8]})
          + ((-(22'sd3 * t3) + 22'sd4 * t2 + t) >>> 1) * $signed({14'h0000, p[23:16]})
          + ((t3 - t2) >>> 1) * $signed({14'h0000, p[31:24]});
    end
    acc = acc >>> 8;
    if (acc < 0) begin
      interp = 8'h00;
    end else if (acc > 22'sd255) begin
      interp = 8'hff;
    end else begin
      interp = acc[7:0];
    end
  endfunction : interp

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic enable_q, single_q, y_en_q, c_en_q, dwn_q;
  logic [POS_W-1:0] vst_q, lines_q;
  logic [POS_W-2:0] hst_q, width_q;
  logic [PH_W-1:0] vph_y_q, vph_c_q, vratio_q, hph_q, hratio_q;
  logic [ADJ_W-1:0] hadj_q;
  logic [1:0] vmeth_q, hmeth_q;
  logic [SMOOTH_W-1:0] vsm_y_q, vsm_c_q;
  logic [31:0] rdata_q;
  logic wr_en;
  logic [31:0] wd;

  assign wr_en = LINK.reg_wr;
  assign wd = LINK.reg_wdata;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      enable_q <= 1'b0;
    end else if (wr_en && LINK.reg_addr == IDX_ENABLE) begin
      enable_q <= wd[0];
    end else if (LINK.vsync_event && single_q) begin
      enable_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      single_q <= 1'b0;
      y_en_q <= 1'b0;
      c_en_q <= 1'b0;
      vst_q <= '0;
      hst_q <= '0;
      lines_q <= '0;
      width_q <= '0;
      vph_y_q <= '0;
      vph_c_q <= '0;
      vratio_q <= RATIO_RESET;
      vmeth_q <= 2'h0;
      vsm_y_q <= '0;
      vsm_c_q <= '0;
      hph_q <= '0;
      hadj_q <= '0;
      hratio_q <= RATIO_RESET;
      hmeth_q <= 2'h0;
      dwn_q <= 1'b0;
    end else if (wr_en) begin
      case (LINK.reg_addr)
        IDX_SINGLE: single_q <= wd[0];
        IDX_SUBSMP: begin
          y_en_q <= wd[0];
          c_en_q <= wd[1];
        end
        IDX_IN_VST: vst_q <= wd[12:0];
        IDX_IN_HST: hst_q <= wd[12:1];
        IDX_O_LINES: lines_q <= wd[12:0];
        IDX_O_WIDTH: width_q <= wd[12:1];
        IDX_V_PH_Y: vph_y_q <= wd[13:0];
        IDX_V_PH_C: vph_c_q <= wd[13:0];
        IDX_V_RATIO: vratio_q <= wd[13:0];
        IDX_V_METH: vmeth_q <= wd[1:0];
        IDX_V_SMOOTH: begin
          vsm_y_q <= wd[5:0];
          vsm_c_q <= wd[11:6];
        end
        IDX_H_PH: hph_q <= wd[13:0];
        IDX_H_PH_ADJ: hadj_q <= wd[8:0];
        IDX_H_RATIO: hratio_q <= wd[13:0];
        IDX_H_METH: hmeth_q <= wd[1:0];
        IDX_DWN: dwn_q <= wd[0];
        default: ;
      endcase
    end
  end

  // Reserved bits are not stored and read back as zero
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rdata_q <= '0;
    end else if (LINK.reg_rd) begin
      case (LINK.reg_addr)
        IDX_ENABLE: rdata_q <= {31'h0, enable_q};
        IDX_SINGLE: rdata_q <= {31'h0, single_q};
        IDX_SUBSMP: rdata_q <= {30'h0, c_en_q, y_en_q};
        IDX_IN_VST: rdata_q <= {19'h0, vst_q};
        IDX_IN_HST: rdata_q <= {19'h0, hst_q, 1'b0};
        IDX_O_LINES: rdata_q <= {19'h0, lines_q};
        IDX_O_WIDTH: rdata_q <= {19'h0, width_q, 1'b0};
        IDX_V_PH_Y: rdata_q <= {18'h0, vph_y_q};
        IDX_V_PH_C: rdata_q <= {18'h0, vph_c_q};
        IDX_V_RATIO: rdata_q <= {18'h0, vratio_q};
        IDX_V_METH: rdata_q <= {30'h0, vmeth_q};
        IDX_V_SMOOTH: rdata_q <= {20'h0, vsm_c_q, vsm_y_q};
        IDX_H_PH: rdata_q <= {18'h0, hph_q};
        IDX_H_PH_ADJ: rdata_q <= {23'h0, hadj_q};
        IDX_H_RATIO: rdata_q <= {18'h0, hratio_q};
        IDX_H_METH: rdata_q <= {30'h0, hmeth_q};
        IDX_DWN: rdata_q <= {31'h0, dwn_q};
        default: rdata_q <= '0;
      endcase
    end
  end

  assign LINK.reg_rdata = rdata_q;
  // The vertical filter bank downstream consumes these settings
  assign V_METHOD = vmeth_q;
  assign V_SMOOTH = {vsm_c_q, vsm_y_q};
  assign V_PHASE_C = vph_c_q;
  assign V_PHASE_Y = vph_y_q;
  assign DOWNSCALE = dwn_q;

  // ----------------------------------------------------------------
  // Frame, line and pixel tracking
  // ----------------------------------------------------------------
  logic active_q, fdone_q;
  logic [POS_W-1:0] in_line_q, in_pix_q, out_line_q, out_pix_q, max_w;
  logic [ACC_W-1:0] v_acc_q, h_acc_q, c_acc_q, h_load, c_load;
  logic [POS_W+1:0] rcv_q;
  logic [31:0] hy_q, hc_q;
  logic [PH_W-1:0] vr_eff, hr_eff;
  logic line_hit, take_px, store_px, emit, last_px, line_done;
  logic [POS_W-1:0] rel_line, w_eff;

  assign vr_eff = eff_ratio(vratio_q, dwn_q);
  assign hr_eff = eff_ratio(hratio_q, dwn_q);
  assign max_w = dwn_q ? WIDTH_MAX_DOWN : WIDTH_MAX_NORMAL;
  assign w_eff = ({width_q, 1'b0} > max_w) ? max_w : {width_q, 1'b0};
  assign h_load = {8'h00, hph_q} + {13'h0000, hadj_q};
  assign c_load = {8'h00, hph_q};
  assign rel_line = in_line_q - vst_q;
  // Only one output line per input line: repeated lines for vertical
  // upscaling need the line store of the vertical filter stage.
  assign line_hit = active_q && !fdone_q && (in_line_q >= vst_q)
                  && (v_acc_q[ACC_W-1:FRAC_W] <= {1'b0, rel_line});
  assign emit = line_hit && (out_pix_q <= w_eff)
              && ({2'b00, h_acc_q[ACC_W-1:FRAC_W]} + 16'd3 <= {1'b0, rcv_q});
  assign LINK.px_ready = !emit; // Stalls the pipe in every cycle that emits an output pixel
  assign take_px = LINK.px_valid && !emit;
  assign store_px = take_px && line_hit && (in_pix_q >= {hst_q, 1'b0});
  assign line_done = take_px && LINK.px_line_end;
  assign last_px = emit && (out_pix_q == w_eff);
  assign FRAME_ACTIVE = active_q;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      active_q <= 1'b0;
      fdone_q <= 1'b0;
      in_line_q <= '0;
      out_line_q <= '0;
      v_acc_q <= '0;
    end else if (LINK.vsync_event) begin
      active_q <= enable_q;
      fdone_q <= 1'b0;
      in_line_q <= '0;
      out_line_q <= '0;
      v_acc_q <= {8'h00, vph_y_q};
    end else if (line_done) begin
      in_line_q <= in_line_q + 13'h0001;
      if (line_hit) begin
        v_acc_q <= v_acc_q + {8'h00, vr_eff};
        out_line_q <= out_line_q + 13'h0001;
        fdone_q <= (out_line_q == lines_q);
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      in_pix_q <= '0;
      rcv_q <= '0;
      out_pix_q <= '0;
      h_acc_q <= '0;
      c_acc_q <= '0;
      hy_q <= '0;
      hc_q <= '0;
    end else if (LINK.vsync_event || line_done) begin
      in_pix_q <= '0;
      rcv_q <= '0;
      out_pix_q <= '0;
      h_acc_q <= h_load;
      c_acc_q <= c_load;
    end else if (emit) begin
      h_acc_q <= h_acc_q + {8'h00, hr_eff};
      c_acc_q <= c_acc_q + {8'h00, hr_eff};
      out_pix_q <= out_pix_q + 13'h0001;
    end else if (take_px) begin
      in_pix_q <= in_pix_q + 13'h0001;
      if (store_px) begin
        rcv_q <= rcv_q + 15'h0001;
        // First sample fills all taps so the left edge is replicated
        hy_q <= (rcv_q == '0) ? {4{LINK.px_data[15:8]}} : {LINK.px_data[15:8], hy_q[31:8]};
        hc_q <= (rcv_q == '0) ? {4{LINK.px_data[7:0]}} : {LINK.px_data[7:0], hc_q[31:8]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic conv, y_out, c_out;
  logic ov_q, oy_en_q, oc_en_q, ole_q, ofe_q;
  logic [7:0] oy_q, oc_q;

  assign conv = LINK.px_is_422 && (y_en_q || c_en_q);
  assign y_out = !conv || y_en_q;
  assign c_out = !conv || (c_en_q && !out_line_q[0]);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ov_q <= 1'b0;
      oy_q <= 8'h00;
      oc_q <= 8'h00;
      oy_en_q <= 1'b0;
      oc_en_q <= 1'b0;
      ole_q <= 1'b0;
      ofe_q <= 1'b0;
    end else begin
      // Every output slot is flagged so line and frame ends always ride on a pixel
      ov_q <= emit;
      ole_q <= last_px;
      ofe_q <= last_px && (out_line_q == lines_q);
      if (emit) begin
        oy_q <= interp(hy_q, h_acc_q[FRAC_W-1:0], hmeth_q[0]);
        oc_q <= interp(hc_q, c_acc_q[FRAC_W-1:0], hmeth_q[1]);
        oy_en_q <= y_out;
        oc_en_q <= c_out;
      end
    end
  end

  assign LINK.out_valid = ov_q;
  assign LINK.out_y = oy_q;
  assign LINK.out_c = oc_q;
  assign LINK.out_y_en = oy_en_q;
  assign LINK.out_c_en = oc_en_q;
  assign LINK.out_line_end = ole_q;
  assign LINK.out_frame_end = ofe_q;

endmodule : irsc_dev

// >>> rtl/irsc_host.sv
// Controller end: APB command registers, pixel source stage, sink capture
`timescale 1ns/1ps
module irsc_host (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SRC_VSYNC,
  input wire logic SRC_IS_422,
  input wire logic SRC_VALID,
  input wire logic [15:0] SRC_DATA,
  input wire logic SRC_LINE_END,
  output logic SRC_READY,
  output logic SNK_VALID,
  output logic [7:0] SNK_Y,
  output logic [7:0] SNK_C,
  output logic SNK_Y_EN,
  output logic SNK_C_EN,
  output logic SNK_LINE_END,
  output logic SNK_FRAME_END,
  irsc_link_if.host LINK
);
  import irsc_pkg::*;

  // ----------------------------------------------------------------
  // APB command registers
  // ----------------------------------------------------------------
  logic [4:0] addr_q;
  logic [31:0] data_q, rd_q, prdata_q;
  logic wr_q, rd_go_q, rd_wait_q, busy_q;
  logic [15:0] pix_cnt_q;
  logic acc_wr, mapped;

  assign mapped = (PADDR == APB_CMD_ADDR) || (PADDR == APB_CMD_DATA)
               || (PADDR == APB_CMD_CTRL) || (PADDR == APB_CMD_RDATA)
               || (PADDR == APB_STATUS);
  assign acc_wr = PSEL && PENABLE && PWRITE && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = prdata_q;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      addr_q <= '0;
      data_q <= '0;
      wr_q <= 1'b0;
      rd_go_q <= 1'b0;
    end else begin
      wr_q <= acc_wr && PADDR == APB_CMD_CTRL && PWDATA[CTRL_WR_BIT];
      rd_go_q <= acc_wr && PADDR == APB_CMD_CTRL && PWDATA[CTRL_RD_BIT];
      if (acc_wr && PADDR == APB_CMD_ADDR) begin
        addr_q <= PWDATA[4:0];
      end
      if (acc_wr && PADDR == APB_CMD_DATA) begin
        data_q <= PWDATA;
      end
    end
  end

  // Read data is sampled one cycle after the request pulse
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rd_wait_q <= 1'b0;
      rd_q <= '0;
      busy_q <= 1'b0;
    end else begin
      rd_wait_q <= rd_go_q;
      if (rd_go_q) begin
        busy_q <= 1'b1;
      end else if (rd_wait_q) begin
        busy_q <= 1'b0;
        rd_q <= LINK.reg_rdata;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      prdata_q <= '0;
    end else if (PSEL && !PENABLE) begin
      case (PADDR)
        APB_CMD_ADDR: prdata_q <= {27'h0, addr_q};
        APB_CMD_DATA: prdata_q <= data_q;
        APB_CMD_RDATA: prdata_q <= rd_q;
        APB_STATUS: prdata_q <= {pix_cnt_q, 15'h0, busy_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  assign LINK.reg_wr = wr_q;
  assign LINK.reg_rd = rd_go_q;
  assign LINK.reg_addr = addr_q;
  assign LINK.reg_wdata = data_q;

  // ----------------------------------------------------------------
  // Pixel source stage, one register deep
  // ----------------------------------------------------------------
  logic pv_q, ple_q, vs_q, f422_q;
  logic [15:0] pd_q;

  assign SRC_READY = !pv_q || LINK.px_ready;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pv_q <= 1'b0;
      pd_q <= '0;
      ple_q <= 1'b0;
      vs_q <= 1'b0;
      f422_q <= 1'b0;
    end else begin
      vs_q <= SRC_VSYNC;
      f422_q <= SRC_IS_422;
      if (SRC_READY) begin
        pv_q <= SRC_VALID;
        pd_q <= SRC_DATA;
        ple_q <= SRC_LINE_END;
      end
    end
  end

  assign LINK.vsync_event = vs_q;
  assign LINK.px_is_422 = f422_q;
  assign LINK.px_valid = pv_q;
  assign LINK.px_data = pd_q;
  assign LINK.px_line_end = ple_q;

  // ----------------------------------------------------------------
  // Sink capture
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      SNK_VALID <= 1'b0;
      SNK_Y <= 8'h00;
      SNK_C <= 8'h00;
      SNK_Y_EN <= 1'b0;
      SNK_C_EN <= 1'b0;
      SNK_LINE_END <= 1'b0;
      SNK_FRAME_END <= 1'b0;
      pix_cnt_q <= '0;
    end else begin
      SNK_VALID <= LINK.out_valid;
      SNK_Y <= LINK.out_y;
      SNK_C <= LINK.out_c;
      SNK_Y_EN <= LINK.out_y_en;
      SNK_C_EN <= LINK.out_c_en;
      SNK_LINE_END <= LINK.out_line_end;
      SNK_FRAME_END <= LINK.out_frame_end;
      if (vs_q) begin
        pix_cnt_q <= '0;
      end else if (LINK.out_valid) begin
        pix_cnt_q <= pix_cnt_q + 16'h0001;
      end
    end
  end

endmodule : irsc_host
